/* logic/tmr_timer8.sv */
// 8-bit timer/counter: counter, two compare units, flags, prescaler
// assumes the cpu drives the register port on core_clk; count pin is async
//
// Contract
// - count and both compares are eight bits
// - tick from prescaler or pin; zero stops
// - bottom is 0x00, max is 0xff
// - top is 0xff or compare a
// - each tick clears, increments or decrements
// - cpu reads and writes count anytime
// - cpu count write beats clear or count
// - three-bit waveform mode across two controls
// - overflow flag set per mode, requests irq
// - count compared with both compares always
// - compare flag set on tick after match
// - flag cleared by service or written one
// - shared flag register, per-request mask bits
// - output from match, mode, output mode
// - pwm double-buffers compares, update at top
// - cpu reaches buffer when buffering active
// - force strobe acts like match in non-pwm modes, no flag
// - count write blocks next-tick match
// - output states kept across mode changes
// - output mode changes take effect immediately
`timescale 1ns/1ns
module tmr_timer8 #(
   parameter int WIDTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [3:0]       regAddr,
   input  wire logic [WIDTH-1:0] regWdata,
   input  wire logic             regWr,
   input  wire logic             regRd,
   output logic      [WIDTH-1:0] regRdata,
   input  wire logic             externalCountPin,
   output logic                  compareOutputA,
   output logic                  compareOutputB,
   output logic                  overflowIrq,
   output logic                  compareIrqA,
   output logic                  compareIrqB
);
   // ==========================================================
   // pin synchroniser, three stages
   logic [2:0] pinSync;
   logic [2:0] next_pinSync;
   logic       pinLevel;
   logic       next_pinLevel;
   always_comb begin
      next_pinSync = {pinSync[1:0], externalCountPin};
      next_pinLevel = pinLevel;
      if (pinSync[2] == pinSync[1]) begin
         next_pinLevel = pinSync[1];
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pinSync  <= 3'h0;
         pinLevel <= 1'b0;
      end else begin
         pinSync  <= next_pinSync;
         pinLevel <= next_pinLevel;
      end
   end

   // ==========================================================
   // registers and state
   tmr_pkg::tmr_ctrl_a_type ctrlA;
   logic [7:0] ctrlB;
   logic [7:0] countValue, compareValueA, compareValueB, bufA, bufB;
   logic [2:0] timerIrqFlagReg, timerIrqMaskReg;
   logic [9:0] prescaler;
   logic       upDown, blockNext, pinPrev;
   logic [7:0] next_ctrlB, next_countValue, next_cmpA, next_cmpB, next_bufA, next_bufB;
   logic [7:0] next_rdata;
   tmr_pkg::tmr_ctrl_a_type next_ctrlA;
   logic [2:0] next_flag, next_mask;
   logic [9:0] next_prescaler;
   logic       next_upDown, next_block, next_outA, next_outB;

   logic [2:0] waveformModeField;
   logic [2:0] clockSelectField;
   logic       timerTick, isPwm, isPhase, atTop, atBottom, matchA, matchB;
   logic [7:0] topValue;

   tmr_pkg::tmr_bus_type bus;
   assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

   assign waveformModeField = {ctrlB[tmr_pkg::CTRLB_WGM_HI], ctrlA.wgmLo};
   assign clockSelectField  = ctrlB[tmr_pkg::CTRLB_CS_LO +: 3];
   assign isPwm   = waveformModeField[0];   // modes 1,3,5,7 are pwm
   assign isPhase = isPwm && !waveformModeField[1];
   assign topValue = (waveformModeField == tmr_pkg::WGM_CTC ||
                      waveformModeField == tmr_pkg::WGM_PC_OCR ||
                      waveformModeField == tmr_pkg::WGM_FAST_OCR)
                     ? compareValueA : tmr_pkg::MAX_VALUE;
   assign atTop    = (countValue == topValue);
   assign atBottom = (countValue == tmr_pkg::BOTTOM_VALUE);
   assign matchA   = (countValue == compareValueA);
   assign matchB   = (countValue == compareValueB);

   // ==========================================================
   // tick select: prescaler taps or falling/rising pin edge
   always_comb begin
      next_prescaler = prescaler + 10'h001;
      case (clockSelectField)
         tmr_pkg::CS_STOP:     timerTick = 1'b0;
         tmr_pkg::CS_DIV1:     timerTick = 1'b1;
         tmr_pkg::CS_DIV8:     timerTick = (prescaler[2:0] == 3'h7);
         tmr_pkg::CS_DIV64:    timerTick = (prescaler[5:0] == 6'h3f);
         tmr_pkg::CS_DIV256:   timerTick = (prescaler[7:0] == 8'hff);
         tmr_pkg::CS_DIV1024:  timerTick = (prescaler == 10'h3ff);
         tmr_pkg::CS_EXT_FALL: timerTick = pinPrev && !pinLevel;
         default:              timerTick = !pinPrev && pinLevel;
      endcase
   end

   // compare output action for one unit
   function automatic logic outAction(input logic cur, input logic [1:0] com,
                                      input logic pwm, input logic phase,
                                      input logic match, input logic bottom,
                                      input logic up);
      logic res;
      res = cur;
      if (!pwm) begin
         case (com)
            tmr_pkg::COM_TOGGLE: res = match ? !cur : cur;
            tmr_pkg::COM_CLEAR:  res = match ? 1'b0 : cur;
            tmr_pkg::COM_SET:    res = match ? 1'b1 : cur;
            default:             res = cur;
         endcase
      end else if (com[1]) begin
         // inverting when low bit set
         if (phase) begin
            if (match) res = up ? com[0] : !com[0];
         end else begin
            if (match) res = com[0];
            else if (bottom) res = !com[0];
         end
      end
      return res;
   endfunction

   // ==========================================================
   // next-state logic
   always_comb begin
      next_ctrlA = ctrlA;
      next_ctrlB = ctrlB & 8'h3f;   // force strobes read as zero
      next_countValue = countValue;
      next_cmpA = compareValueA;
      next_cmpB = compareValueB;
      next_bufA = bufA;
      next_bufB = bufB;
      next_flag = timerIrqFlagReg;
      next_mask = timerIrqMaskReg;
      next_upDown = upDown;
      next_block = blockNext;
      next_outA = compareOutputA;   // held across mode changes
      next_outB = compareOutputB;
      next_rdata = tmr_pkg::ZERO_BYTE;

      if (timerTick) begin
         next_block = 1'b0;
         // count sequence
         if (isPhase) begin
            if (upDown && atTop) begin
               next_upDown = 1'b0;
               next_countValue = countValue - 8'h01;
            end else if (!upDown && atBottom) begin
               next_upDown = 1'b1;
               next_countValue = countValue + 8'h01;
            end else begin
               next_countValue = upDown ? countValue + 8'h01 : countValue - 8'h01;
            end
         end else if (atTop && waveformModeField != tmr_pkg::WGM_NORMAL) begin
            next_countValue = tmr_pkg::BOTTOM_VALUE;
         end else begin
            next_countValue = countValue + 8'h01;
            next_upDown = 1'b1;
         end
         // overflow point per mode
         if ((isPhase && atBottom) || (isPwm && !isPhase && atTop) ||
             (!isPwm && countValue == tmr_pkg::MAX_VALUE)) begin
            next_flag[tmr_pkg::FLAG_OVF] = 1'b1;
         end
         if (!blockNext) begin
            if (matchA) next_flag[tmr_pkg::FLAG_CMPA] = 1'b1;
            if (matchB) next_flag[tmr_pkg::FLAG_CMPB] = 1'b1;
            next_outA = outAction(compareOutputA, ctrlA.comA, isPwm, isPhase,
                                  matchA, atBottom, upDown);
            next_outB = outAction(compareOutputB, ctrlA.comB, isPwm, isPhase,
                                  matchB, atBottom, upDown);
         end
         // buffered update at top, in both fast and phase-correct pwm
         if (isPwm && ((isPhase && atTop) || (!isPhase && atTop))) begin
            next_cmpA = bufA;
            next_cmpB = bufB;
         end
      end

      if (bus.wr) begin
         case (bus.addr)
            tmr_pkg::ADDR_CTRL_A: next_ctrlA = tmr_pkg::tmr_ctrl_a_type'(bus.wdata);
            tmr_pkg::ADDR_CTRL_B: begin
               next_ctrlB = bus.wdata & 8'h3f;
               if (!isPwm) begin
                  // forced match updates outputs only
                  if (bus.wdata[tmr_pkg::CTRLB_FOCA])
                     next_outA = outAction(compareOutputA, ctrlA.comA, 1'b0, 1'b0,
                                           1'b1, 1'b0, 1'b1);
                  if (bus.wdata[tmr_pkg::CTRLB_FOCB])
                     next_outB = outAction(compareOutputB, ctrlA.comB, 1'b0, 1'b0,
                                           1'b1, 1'b0, 1'b1);
               end
            end
            tmr_pkg::ADDR_COUNT: begin
               next_countValue = bus.wdata;
               next_block = 1'b1;
            end
            tmr_pkg::ADDR_CMP_A: begin
               if (isPwm) next_bufA = bus.wdata;
               else next_cmpA = bus.wdata;
            end
            tmr_pkg::ADDR_CMP_B: begin
               if (isPwm) next_bufB = bus.wdata;
               else next_cmpB = bus.wdata;
            end
            // write one clears; a same-cycle set is kept
            tmr_pkg::ADDR_IRQ_FLAG: next_flag = next_flag &
                                     ~(bus.wdata[2:0] & ~(next_flag & ~timerIrqFlagReg));
            tmr_pkg::ADDR_IRQ_MASK: next_mask = bus.wdata[2:0];
            // service acknowledge clears the flag
            tmr_pkg::ADDR_ACK:      next_flag = next_flag &
                                     ~(bus.wdata[2:0] & ~(next_flag & ~timerIrqFlagReg));
            default: ;
         endcase
      end

      if (bus.rd) begin
         case (bus.addr)
            tmr_pkg::ADDR_CTRL_A:   next_rdata = ctrlA;
            tmr_pkg::ADDR_CTRL_B:   next_rdata = ctrlB;
            tmr_pkg::ADDR_COUNT:    next_rdata = countValue;
            tmr_pkg::ADDR_CMP_A:    next_rdata = isPwm ? bufA : compareValueA;
            tmr_pkg::ADDR_CMP_B:    next_rdata = isPwm ? bufB : compareValueB;
            tmr_pkg::ADDR_IRQ_FLAG: next_rdata = {5'h00, timerIrqFlagReg};
            tmr_pkg::ADDR_IRQ_MASK: next_rdata = {5'h00, timerIrqMaskReg};
            default:                next_rdata = tmr_pkg::ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrlA <= '0;
         ctrlB <= tmr_pkg::ZERO_BYTE;
         countValue <= tmr_pkg::ZERO_BYTE;
         compareValueA <= tmr_pkg::ZERO_BYTE;
         compareValueB <= tmr_pkg::ZERO_BYTE;
         bufA <= tmr_pkg::ZERO_BYTE;
         bufB <= tmr_pkg::ZERO_BYTE;
         timerIrqFlagReg <= 3'h0;
         timerIrqMaskReg <= 3'h0;
         prescaler <= 10'h000;
         upDown <= 1'b1;
         blockNext <= 1'b0;
         pinPrev <= 1'b0;
         compareOutputA <= 1'b0;
         compareOutputB <= 1'b0;
         regRdata <= tmr_pkg::ZERO_BYTE;
         overflowIrq <= 1'b0;
         compareIrqA <= 1'b0;
         compareIrqB <= 1'b0;
      end else begin
         ctrlA <= next_ctrlA;
         ctrlB <= next_ctrlB;
         countValue <= next_countValue;
         compareValueA <= next_cmpA;
         compareValueB <= next_cmpB;
         bufA <= next_bufA;
         bufB <= next_bufB;
         timerIrqFlagReg <= next_flag;
         timerIrqMaskReg <= next_mask;
         prescaler <= next_prescaler;
         upDown <= next_upDown;
         blockNext <= next_block;
         pinPrev <= pinLevel;
         compareOutputA <= next_outA;
         compareOutputB <= next_outB;
         regRdata <= next_rdata;
         overflowIrq <= next_flag[tmr_pkg::FLAG_OVF] & next_mask[tmr_pkg::FLAG_OVF];
         compareIrqA <= next_flag[tmr_pkg::FLAG_CMPA] & next_mask[tmr_pkg::FLAG_CMPA];
         compareIrqB <= next_flag[tmr_pkg::FLAG_CMPB] & next_mask[tmr_pkg::FLAG_CMPB];
      end
   end

   // ==========================================================
   // assertions
   a_stop_freezes: assert property (@(posedge core_clk) disable iff (rst)
      (clockSelectField == tmr_pkg::CS_STOP && !bus.wr) |=> $stable(countValue))
      else $error("count moved while stopped");
   a_write_wins: assert property (@(posedge core_clk) disable iff (rst)
      (bus.wr && bus.addr == tmr_pkg::ADDR_COUNT) |=> countValue == $past(bus.wdata))
      else $error("count write lost");
   a_block_match: assert property (@(posedge core_clk) disable iff (rst)
      (blockNext && timerTick && !timerIrqFlagReg[tmr_pkg::FLAG_CMPA]
       && !(bus.wr)) |=> !timerIrqFlagReg[tmr_pkg::FLAG_CMPA])
      else $error("match not blocked after count write");
   a_flag_on_tick: assert property (@(posedge core_clk) disable iff (rst)
      (timerTick && matchA && !blockNext) |=> timerIrqFlagReg[tmr_pkg::FLAG_CMPA])
      else $error("compare flag a not set");
   a_irq_masked: assert property (@(posedge core_clk) disable iff (rst)
      compareIrqB |-> timerIrqMaskReg[tmr_pkg::FLAG_CMPB] && timerIrqFlagReg[tmr_pkg::FLAG_CMPB])
      else $error("unmasked compare irq b");
   a_direct_write: assert property (@(posedge core_clk) disable iff (rst)
      (bus.wr && bus.addr == tmr_pkg::ADDR_CMP_B && !isPwm) |=> compareValueB == $past(bus.wdata))
      else $error("direct compare write missed");
   a_ctc_clear: assert property (@(posedge core_clk) disable iff (rst)
      (timerTick && waveformModeField == tmr_pkg::WGM_CTC && atTop && !bus.wr)
      |=> countValue == tmr_pkg::BOTTOM_VALUE)
      else $error("ctc did not clear");
   a_normal_ovf: assert property (@(posedge core_clk) disable iff (rst)
      (timerTick && waveformModeField == tmr_pkg::WGM_NORMAL
       && countValue == tmr_pkg::MAX_VALUE) |=> timerIrqFlagReg[tmr_pkg::FLAG_OVF])
      else $error("overflow flag not set");
   a_force_no_flag: assert property (@(posedge core_clk) disable iff (rst)
      (bus.wr && bus.addr == tmr_pkg::ADDR_CTRL_B && !timerTick
       && !timerIrqFlagReg[tmr_pkg::FLAG_CMPA]) |=> !timerIrqFlagReg[tmr_pkg::FLAG_CMPA])
      else $error("force strobe set compare flag a");
   a_buffer_load: assert property (@(posedge core_clk) disable iff (rst)
      (timerTick && isPwm && atTop && !bus.wr)
      |=> compareValueA == $past(bufA))
      else $error("buffered compare a not loaded at top");
   a_phase_ovf: assert property (@(posedge core_clk) disable iff (rst)
      (timerTick && isPhase && atBottom)
      |=> timerIrqFlagReg[tmr_pkg::FLAG_OVF])
      else $error("phase-correct overflow not set at bottom");
   a_pwm_buffered: assert property (@(posedge core_clk) disable iff (rst)
      (bus.wr && bus.addr == tmr_pkg::ADDR_CMP_A && isPwm && !timerTick)
      |=> $stable(compareValueA))
      else $error("pwm compare write reached active register");
endmodule

/* include/tmr_pkg.sv */
// package for the 8-bit timer/counter with two compare units
// assumes a single core clock and a plain register port from the cpu
package tmr_pkg;
   // ==========================================================
   // register indices
   localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
   localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
   localparam logic [3:0] ADDR_COUNT    = 4'h2;
   localparam logic [3:0] ADDR_CMP_A    = 4'h3;
   localparam logic [3:0] ADDR_CMP_B    = 4'h4;
   localparam logic [3:0] ADDR_IRQ_FLAG = 4'h5;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
   localparam logic [3:0] ADDR_ACK      = 4'h7;
   localparam logic [3:0] ADDR_PRESCALE = 4'h8;

   // ==========================================================
   // field positions
   localparam int CTRLA_WGM_LO  = 0;   // two low waveform mode bits
   localparam int CTRLA_COMB_LO = 4;
   localparam int CTRLA_COMA_LO = 6;
   localparam int CTRLB_CS_LO   = 0;
   localparam int CTRLB_WGM_HI  = 3;
   localparam int CTRLB_FOCB    = 6;
   localparam int CTRLB_FOCA    = 7;
   localparam int FLAG_OVF      = 1;
   localparam int FLAG_CMPA     = 0;
   localparam int FLAG_CMPB     = 2;

   localparam logic [7:0] BOTTOM_VALUE = 8'h00;
   localparam logic [7:0] MAX_VALUE    = 8'hff;
   localparam logic [7:0] ZERO_BYTE    = 8'h00;

   // ==========================================================
   // waveform modes
   localparam logic [2:0] WGM_NORMAL   = 3'h0;
   localparam logic [2:0] WGM_PC_FF    = 3'h1;
   localparam logic [2:0] WGM_CTC      = 3'h2;
   localparam logic [2:0] WGM_FAST_FF  = 3'h3;
   localparam logic [2:0] WGM_PC_OCR   = 3'h5;
   localparam logic [2:0] WGM_FAST_OCR = 3'h7;

   // clock select codes
   localparam logic [2:0] CS_STOP    = 3'h0;
   localparam logic [2:0] CS_DIV1    = 3'h1;
   localparam logic [2:0] CS_DIV8    = 3'h2;
   localparam logic [2:0] CS_DIV64   = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;

   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmr_bus_type;

   typedef struct packed {
      logic [1:0] comA;
      logic [1:0] comB;
      logic [1:0] unused;
      logic [1:0] wgmLo;
   } tmr_ctrl_a_type;
endpackage

/* verif/tmr_pin_model.sv */
// =============================================
// count pin source standing in for the external event line
// assumes pulses are slow enough for the 3-flop sync inside the timer
`timescale 1ns/1ns
module tmr_pin_model (
   input  wire logic core_clk,
   output logic      pin
);
   initial pin = 1'b0;
   // four cycles per level so both edges survive the sync stage
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge core_clk);
         pin <= 1'b1;
         repeat (4) @(posedge core_clk);
         pin <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
   endtask
endmodule

/* verif/test_tmr_timer8.sv */
// =============================================
// self-checking bench for the 8-bit timer with two compare units
// assumes register reads answer one cycle after the read strobe
`timescale 1ns/1ns
module test_tmr_timer8;
   logic       core_clk;
   logic       rst;
   logic [3:0] regAddr;
   logic [7:0] regWdata;
   logic       regWr;
   logic       regRd;
   logic [7:0] regRdata;
   logic       countPin;
   logic       outA;
   logic       outB;
   logic       irqOvf;
   logic       irqA;
   logic       irqB;
   int         err_count;
   int         comparisons;
   // outputs are picked by index so chkbit reads them after its wait
   logic [4:0] probes;
   localparam int OUT_A   = 0;
   localparam int OUT_B   = 1;
   localparam int IRQ_OVF = 2;
   localparam int IRQ_A   = 3;
   localparam int IRQ_B   = 4;
   assign probes = {irqB, irqA, irqOvf, outB, outA};

   tmr_timer8 dut_u (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .externalCountPin(countPin), .compareOutputA(outA), .compareOutputB(outB),
      .overflowIrq(irqOvf), .compareIrqA(irqA), .compareIrqB(irqB));
   tmr_pin_model pin_u (.core_clk(core_clk), .pin(countPin));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // =============================================
   // bus and compare helpers
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkrd(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge core_clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      chk(n, e, regRdata);
   endtask
   task automatic chkbit(input string n, input logic e, input int sel);
      repeat (2) @(posedge core_clk);
      #1;
      chk(n, {7'h00, e}, {7'h00, probes[sel]});
   endtask
   // run with a clock source for n pin pulses, then freeze the counter
   task automatic run(input logic [7:0] ctrlB, input int n);
      wr(tmr_pkg::ADDR_CTRL_B, ctrlB);
      pin_u.pulse(n);
      repeat (6) @(posedge core_clk);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h00);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // =============================================
   // scenarios
   task automatic t_reset;
      chkbit("outA", 1'b0, OUT_A);
      chkbit("outB", 1'b0, OUT_B);
      chkrd(tmr_pkg::ADDR_COUNT, 8'h00, "count");
      chkrd(tmr_pkg::ADDR_IRQ_FLAG, 8'h00, "flags");
      chkrd(4'hf, 8'h00, "unmapped");
   endtask
   task automatic t_force;
      wr(tmr_pkg::ADDR_COUNT, 8'h33);
      wr(tmr_pkg::ADDR_CTRL_A, 8'hc0);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h80);   // set output A before use
      chkbit("outA set", 1'b1, OUT_A);
      wr(tmr_pkg::ADDR_CTRL_A, 8'h80);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h80);
      chkbit("outA clear", 1'b0, OUT_A);
      wr(tmr_pkg::ADDR_CTRL_A, 8'h10);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h40);
      chkbit("outB toggle", 1'b1, OUT_B);
      wr(tmr_pkg::ADDR_CTRL_A, 8'h02);
      chkbit("outB kept", 1'b1, OUT_B);
      chkrd(tmr_pkg::ADDR_IRQ_FLAG, 8'h00, "force no flag");
      chkrd(tmr_pkg::ADDR_COUNT, 8'h33, "force no reload");
   endtask
   task automatic t_prescale;
      int div [1:5];
      div = '{1, 8, 64, 256, 1024};
      wr(tmr_pkg::ADDR_CTRL_A, 8'h00);
      for (int c = 1; c <= 5; c++) begin
         wr(tmr_pkg::ADDR_COUNT, 8'h00);
         wr(tmr_pkg::ADDR_CTRL_B, c[7:0]);
         repeat (4 * div[c] - 2) @(posedge core_clk);
         wr(tmr_pkg::ADDR_CTRL_B, 8'h00);
         // 4*div running clocks hold exactly four taps, whatever the phase
         chkrd(tmr_pkg::ADDR_COUNT, 8'h04, "prescaled count");
      end
      repeat (20) @(posedge core_clk);
      chkrd(tmr_pkg::ADDR_COUNT, 8'h04, "stopped");
   endtask
   task automatic t_normal;
      wr(tmr_pkg::ADDR_CTRL_A, 8'h00);
      wr(tmr_pkg::ADDR_CMP_A, 8'h02);
      wr(tmr_pkg::ADDR_CMP_B, 8'h80);
      wr(tmr_pkg::ADDR_COUNT, 8'hfd);
      wr(tmr_pkg::ADDR_IRQ_FLAG, 8'h07);
      wr(tmr_pkg::ADDR_IRQ_MASK, 8'h07);
      run(8'h07, 6);
      chkrd(tmr_pkg::ADDR_COUNT, 8'h03, "wrap count");
      chkrd(tmr_pkg::ADDR_IRQ_FLAG, 8'h03, "ovf and A");
      chkbit("irqOvf", 1'b1, IRQ_OVF);
      chkbit("irqA", 1'b1, IRQ_A);
      chkbit("irqB", 1'b0, IRQ_B);
      wr(tmr_pkg::ADDR_IRQ_MASK, 8'h01);
      chkbit("ovf masked", 1'b0, IRQ_OVF);
      chkbit("A unmasked", 1'b1, IRQ_A);
      wr(tmr_pkg::ADDR_IRQ_FLAG, 8'h02);
      wr(tmr_pkg::ADDR_ACK, 8'h01);
      chkrd(tmr_pkg::ADDR_IRQ_FLAG, 8'h00, "cleared");
      chkbit("irqA gone", 1'b0, IRQ_A);
      wr(tmr_pkg::ADDR_IRQ_MASK, 8'h07);
   endtask
   task automatic t_ctc;
      wr(tmr_pkg::ADDR_CTRL_A, 8'h02);
      wr(tmr_pkg::ADDR_CMP_A, 8'h03);
      wr(tmr_pkg::ADDR_COUNT, 8'h00);
      wr(tmr_pkg::ADDR_IRQ_FLAG, 8'h07);
      run(8'h06, 5);
      chkrd(tmr_pkg::ADDR_COUNT, 8'h01, "ctc count");
      chkrd(tmr_pkg::ADDR_IRQ_FLAG, 8'h01, "ctc flags");
   endtask
   task automatic t_block;
      wr(tmr_pkg::ADDR_CTRL_A, 8'h00);
      wr(tmr_pkg::ADDR_CMP_B, 8'h0a);
      wr(tmr_pkg::ADDR_COUNT, 8'h0a);   // equal on purpose
      wr(tmr_pkg::ADDR_IRQ_FLAG, 8'h07);
      run(8'h07, 1);
      chkrd(tmr_pkg::ADDR_COUNT, 8'h0b, "block count");
      chkrd(tmr_pkg::ADDR_IRQ_FLAG, 8'h00, "blocked");
      wr(tmr_pkg::ADDR_COUNT, 8'h09);
      run(8'h07, 2);
      chkrd(tmr_pkg::ADDR_IRQ_FLAG, 8'h04, "B match");
   endtask
   task automatic t_pwm;
      logic held;
      wr(tmr_pkg::ADDR_CTRL_A, 8'h03);
      wr(tmr_pkg::ADDR_COUNT, 8'h00);
      wr(tmr_pkg::ADDR_CMP_A, 8'h10);   // lands in the buffer only
      wr(tmr_pkg::ADDR_IRQ_FLAG, 8'h07);
      run(8'h07, 5);
      chkrd(tmr_pkg::ADDR_COUNT, 8'h05, "pwm count");
      chkrd(tmr_pkg::ADDR_IRQ_FLAG, 8'h01, "old compare");
      held = outA;
      wr(tmr_pkg::ADDR_CTRL_A, 8'hc3);
      wr(tmr_pkg::ADDR_CTRL_B, 8'h80);
      chkbit("pwm force", held, OUT_A);
   endtask
   // phase-correct: turn at top loads buffers, overflow at bottom
   task automatic t_phase;
      wr(tmr_pkg::ADDR_CTRL_A, 8'h01);
      wr(tmr_pkg::ADDR_COUNT, 8'hfe);
      wr(tmr_pkg::ADDR_IRQ_FLAG, 8'h07);
      run(8'h07, 3);
      chkrd(tmr_pkg::ADDR_COUNT, 8'hfd, "phase turn at top");
      wr(tmr_pkg::ADDR_COUNT, 8'h01);
      run(8'h07, 2);
      chkrd(tmr_pkg::ADDR_COUNT, 8'h01, "phase turn at bottom");
      chkrd(tmr_pkg::ADDR_IRQ_FLAG, 8'h06, "ovf and loaded B");
   endtask

   initial begin
      rst         = 1'b1;
      regAddr     = 4'h0;
      regWdata    = 8'h00;
      regWr       = 1'b0;
      regRd       = 1'b0;
      err_count   = 0;
      comparisons = 0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_force();
      t_prescale();
      t_normal();
      t_ctc();
      t_block();
      t_pwm();
      t_phase();
      end_of_test();
   end

   // prescale sweep needs about 5.5k cycles, the rest well under 2k
   initial begin
      #(40 * 40000);
      err_count++;
      end_of_test();
   end
endmodule
